//--- rtl/tcc_pkg.sv
// Constants, field layouts and state codes of the tape command block.
package tcc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Instruction codes seen on the register port (low six bits).
  localparam logic [5:0] A_LOAD_COUNT = 6'h01;
  localparam logic [5:0] A_CLR_ADDR = 6'h02;
  localparam logic [5:0] A_LOAD_ADDR = 6'h03;
  localparam logic [5:0] A_LOAD_CMD = 6'h05;
  localparam logic [5:0] A_LOAD_FUNC = 6'h06;
  localparam logic [5:0] A_LOAD_DATA = 6'h07;
  localparam logic [5:0] A_SKIP_ERR = 6'h08;
  localparam logic [5:0] A_RD_COUNT = 6'h09;
  localparam logic [5:0] A_SKIP_IDLE = 6'h0A;
  localparam logic [5:0] A_RD_ADDR = 6'h0B;
  localparam logic [5:0] A_RD_MAIN = 6'h0C;
  localparam logic [5:0] A_RD_SECOND = 6'h0D;
  localparam logic [5:0] A_RD_FUNC = 6'h0E;
  localparam logic [5:0] A_RD_DATA = 6'h0F;
  localparam logic [5:0] A_SKIP_READY = 6'h10;
  localparam logic [5:0] A_SKIP_DONE = 6'h11;
  localparam logic [5:0] A_CLR_FLAGS = 6'h15;
  localparam logic [5:0] A_SET_REQ = 6'h17;
  localparam logic [5:0] A_INIT = 6'h18;
  ////////////////////////////////////////////////////////////////////////
  // Word bit n (bit 0 is the most significant) sits at index 11-n.
  localparam int FN_GAP = 8;
  localparam int FN_CHK = 7;
  localparam int FN_GO = 6;
  localparam int FN_FIELD = 5;
  localparam int FN_DUMP = 4;
  localparam int CM_PARITY = 8;
  localparam int CM_ERR_IE = 7;
  localparam int CM_DONE_IE = 6;
  localparam int MS_ERROR = 11;
  localparam int MS_CHANGE = 10;
  localparam int MS_MISMATCH = 9;
  localparam int MS_EOT = 3;
  localparam int MS_BOT = 9;
  localparam int MS_LATE = 4;
  localparam int MS_RECLEN = 5;
  localparam int MS_MARK = 6;
  localparam int MS_PARITY = 7;
  localparam int MS_SELERR = 8;
  localparam int MS_ILLEGAL = 0;
  localparam int SS_CHK = 7;
  localparam int SS_OVERRUN = 3;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [2:0] FIELD_LAST = 3'h7;
  ////////////////////////////////////////////////////////////////////////
  // Function codes held in the top three function bits.
  localparam logic [2:0] FC_UNLOAD_TO_LOCAL = 3'h0;
  localparam logic [2:0] FC_REWIND = 3'h1;
  localparam logic [2:0] FC_READ = 3'h2;
  localparam logic [2:0] FC_COMPARE = 3'h3;
  localparam logic [2:0] FC_WRITE = 3'h4;
  localparam logic [2:0] FC_MARK = 3'h5;
  localparam logic [2:0] FC_FWD = 3'h6;
  localparam logic [2:0] FC_REV = 3'h7;
  ////////////////////////////////////////////////////////////////////////
  // Pulse timing at a 4 ns clock; least widths round up.
  localparam int CLK_PERIOD_NS = 4;
  localparam int PRESET_TIME_NS = 2500;
  localparam int START_TIME_NS = 5000;
  localparam int PRESET_CYCLES =
    (PRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYCLES =
    (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer states.
  typedef enum logic [3:0] {
    TCC_IDLE = 4'b0001,
    TCC_PRESET = 4'b0010,
    TCC_START = 4'b0100,
    TCC_RUN = 4'b1000
  } tcc_state_t;
endpackage

//--- rtl/tcc_pulse_timer.sv
// One-shot pulse of a fixed number of cycles with an end strobe.
`timescale 1ns/1ps
module tcc_pulse_timer #(
  parameter int CYCLES = 625
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic fire_in,
  output logic pulse_out,
  output logic end_out
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_q;
  logic pulse_q;
  logic end_q;

  // A pulse shorter than one cycle cannot be produced.
  generate
    if (CYCLES < 1) begin : g_bad
      $error("tcc_pulse_timer: CYCLES must be at least one");
    end
  endgenerate

  // The count runs down while the pulse stands; a new fire restarts it.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
      pulse_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      end_q <= pulse_q && (count_q == CW'(1)) && !fire_in;
      if (fire_in) begin
        count_q <= CW'(CYCLES);
        pulse_q <= 1'b1;
      end else if (pulse_q) begin
        count_q <= count_q - CW'(1);
        pulse_q <= (count_q != CW'(1));
      end
    end
  end

  assign pulse_out = pulse_q;
  assign end_out = end_q;
endmodule // tcc_pulse_timer

//--- rtl/tcc_tape_control.sv
// Command, status, skip and break logic of the tape controller.
`timescale 1ns/1ps
module tcc_tape_control (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic bus_init_in,
  input wire logic power_fail_in,
  input wire logic [5:0] addr_in,
  input wire logic [11:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic break_grant_in,
  input wire logic [11:0] mem_data_in,
  input wire logic unit_ready_in,
  input wire logic tape_end_marker_in,
  input wire logic tape_start_marker_in,
  input wire logic [2:0] parity_err_in,
  input wire logic file_mark_in,
  input wire logic select_error_in,
  input wire logic char_strobe_in,
  input wire logic record_end_in,
  input wire logic [7:0] read_data_in,
  output logic [11:0] rdata_out,
  output logic skip_out,
  output logic interrupt_out,
  output logic transfer_request_out,
  output logic [14:0] break_addr_out,
  output logic [11:0] break_data_out,
  output logic [2:0] unit_select_out,
  output logic extended_gap_out,
  output logic parity_sense_select_out,
  output logic check_char_enable_out,
  output logic unload_to_local_out,
  output logic rewind_out,
  output logic write_mark_out,
  output logic space_ahead_out,
  output logic space_back_out,
  output logic spacing_out,
  output logic preset_out,
  output logic start_pulse_out,
  output logic [7:0] write_data_out
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, then a third stage for edges.
  localparam int SW = 18;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic strobe_d1_q;
  logic recend_d1_q;
  assign pin_raw = {read_data_in, record_end_in, char_strobe_in,
                    select_error_in, file_mark_in, parity_err_in,
                    tape_start_marker_in, tape_end_marker_in,
                    unit_ready_in};
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        sync1_q[gi] <= pin_raw[gi];
        sync2_q[gi] <= sync1_q[gi];
      end
    end
  endgenerate

  wire ready = sync2_q[0];
  wire at_end = sync2_q[1];
  wire at_start = sync2_q[2];
  wire par_err = |sync2_q[5:3];
  wire mark_seen = sync2_q[6];
  wire sel_err = sync2_q[7];
  wire char_ev = sync2_q[8] && !strobe_d1_q;
  wire rec_ev = sync2_q[9] && !recend_d1_q;
  wire [7:0] rd_bits = sync2_q[17:10];

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  tcc_state_t state_q;
  tcc_state_t state_d;
  logic [11:0] cmd_q, fn_q, wc_q, ca_q, db_q;
  logic [2:0] field_q, bsel_q;
  logic [11:0] ms_q;
  logic ovr_q, err_q, done_q, busy_q, go_seen_q, req_q;
  logic [11:0] rdata_q;
  logic skip_q, irq_q;
  logic gap_q, par_q, chk_q, offl_q, rew_q, mark_q, fwd_q, rev_q, spc_q;
  logic [7:0] wd_q;
  logic preset_pulse, preset_end, start_pulse, start_end;

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode and clear sources.
  wire wr_cmd = wr_in && addr_in == A_LOAD_CMD;
  wire wr_fn = wr_in && addr_in == A_LOAD_FUNC;
  wire wr_wc = wr_in && addr_in == A_LOAD_COUNT;
  wire wr_db = wr_in && addr_in == A_LOAD_DATA;
  wire wr_clf = wr_in && addr_in == A_CLR_FLAGS;
  wire wr_init = wr_in && addr_in == A_INIT;
  wire clear_everything = !reset_n_in || bus_init_in || power_fail_in ||
                 wr_init || (wr_clf && ready);
  wire clr_stat = clear_everything || wr_clf;
  wire [2:0] code = fn_q[11:9];
  wire running = state_q == TCC_RUN;
  wire op_read = code == FC_READ || code == FC_COMPARE;
  wire op_data = op_read || code == FC_WRITE;
  wire op_space = code == FC_FWD || code == FC_REV;
  wire go_new = wr_fn && wdata_in[FN_GO];
  wire wc_zero = wc_q == WORD_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Data path: core dump zeroes tape bits 0 and 1.
  wire [7:0] rd_eff = fn_q[FN_DUMP] ? {rd_bits[7:2], 2'h0} : rd_bits;
  wire grant_ok = break_grant_in && req_q;
  wire mism_ev = grant_ok && running && code == FC_COMPARE &&
                 mem_data_in != db_q;
  wire ca_wrap = ca_q == 12'hFFF;
  wire ca_step = grant_ok && !ms_q[MS_MISMATCH];
  wire ovr_ev = ca_step && ca_wrap && fn_q[FN_FIELD] &&
                field_q == FIELD_LAST;
  wire late_ev = char_ev && running && op_data && req_q &&
                 !break_grant_in;
  wire reclen_ev = running && op_read &&
                   ((rec_ev && !wc_zero) ||
                    (char_ev && wc_zero));
  wire eot_ev = at_end;
  wire bot_ev = at_start && running && code == FC_REV;
  wire ill_ev = go_new && !ready;
  wire chg_ev = bsel_q != cmd_q[11:9];
  wire wc_step = (grant_ok && op_data) || (rec_ev && running && op_space);
  wire wc_next_zero = wc_step && wc_q == 12'hFFF;
  wire space_stop = running && op_space &&
                    (at_end || mark_seen || wc_next_zero);
  wire data_stop = running && op_data && (wc_next_zero || rec_ev);
  wire done_ev = wr_db || space_stop || data_stop ||
                 (state_q == TCC_START && start_end && !op_data &&
                  !op_space);

  // Sticky status sets; a set in the clearing cycle wins.
  logic [11:0] ms_set;
  always_comb begin
    ms_set = 12'h000;
    ms_set[MS_CHANGE] = chg_ev;
    ms_set[MS_MISMATCH] = mism_ev || bot_ev;
    ms_set[MS_EOT] = eot_ev;
    ms_set[MS_LATE] = late_ev;
    ms_set[MS_RECLEN] = reclen_ev;
    ms_set[MS_MARK] = mark_seen && running;
    ms_set[MS_PARITY] = par_err;
    ms_set[MS_SELERR] = sel_err && running;
    ms_set[MS_ILLEGAL] = ill_ev;
    ms_set[MS_ERROR] = |ms_set[MS_CHANGE-1:0] || ovr_ev;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: go with ready gives preset, then start, then run for data and spacing codes.
  always_comb begin
    state_d = state_q;
    case (state_q)
      TCC_IDLE: begin
        if (go_new && ready) begin
          state_d = TCC_PRESET;
        end
      end
      TCC_PRESET: begin
        if (preset_end) begin
          state_d = TCC_START;
        end
      end
      TCC_START: begin
        if (start_end) begin
          state_d = (op_data || op_space) ? TCC_RUN : TCC_IDLE;
        end
      end
      TCC_RUN: begin
        if (space_stop || data_stop) begin
          state_d = TCC_IDLE;
        end
      end
      default: state_d = TCC_IDLE;
    endcase
  end

  tcc_pulse_timer #(.CYCLES(PRESET_CYCLES)) u_preset (
    .clk_in(clk_in),
    .reset_n_in(!clear_everything),
    .fire_in(state_q == TCC_IDLE && state_d == TCC_PRESET),
    .pulse_out(preset_pulse),
    .end_out(preset_end)
  );

  tcc_pulse_timer #(.CYCLES(START_CYCLES)) u_start (
    .clk_in(clk_in),
    .reset_n_in(!clear_everything),
    .fire_in(preset_end),
    .pulse_out(start_pulse),
    .end_out(start_end)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control registers, counters and flags.
  always_ff @(posedge clk_in) begin
    if (clear_everything) begin
      state_q <= TCC_IDLE;
      cmd_q <= 12'h000;
      fn_q <= 12'h000;
      wc_q <= 12'h000;
      ca_q <= 12'h000;
      db_q <= 12'h000;
      field_q <= 3'h0;
      bsel_q <= 3'h0;
      ovr_q <= 1'b0;
      busy_q <= 1'b0;
      go_seen_q <= 1'b0;
      req_q <= 1'b0;
      strobe_d1_q <= 1'b0;
      recend_d1_q <= 1'b0;
    end else begin
      state_q <= state_d;
      strobe_d1_q <= sync2_q[8];
      recend_d1_q <= sync2_q[9];
      if (wr_cmd) begin
        cmd_q <= wdata_in;
        field_q <= wdata_in[5:3];
      end else if (ca_step && ca_wrap && fn_q[FN_FIELD] &&
                   field_q != FIELD_LAST) begin
        field_q <= field_q + 3'h1;
      end
      if (wr_fn) begin
        fn_q <= wdata_in;
      end
      if (wr_wc) begin
        wc_q <= wdata_in;
      end else if (wc_step) begin
        wc_q <= wc_q + 12'h001;
      end
      if (wr_in && addr_in == A_CLR_ADDR) begin
        ca_q <= 12'h000;
      end else if (wr_in && addr_in == A_LOAD_ADDR) begin
        ca_q <= wdata_in;
      end else if (ca_step) begin
        ca_q <= ca_q + 12'h001;
      end
      if (wr_db) begin
        db_q <= wdata_in;
      end else if (char_ev && running && op_read) begin
        db_q <= {4'h0, rd_eff};
      end else if (grant_ok && code == FC_WRITE) begin
        db_q <= mem_data_in;
      end
      if (start_pulse && !bsel_q[0] && state_q == TCC_START) begin
        bsel_q <= cmd_q[11:9];
      end else if (preset_end) begin
        bsel_q <= cmd_q[11:9];
      end
      ovr_q <= ovr_q || ovr_ev;
      go_seen_q <= go_new;
      if (go_seen_q) begin
        busy_q <= 1'b1;
      end else if (done_ev) begin
        busy_q <= 1'b0;
      end
      if ((char_ev && running && op_data) ||
          (wr_in && addr_in == A_SET_REQ)) begin
        req_q <= 1'b1;
      end else if (break_grant_in) begin
        req_q <= 1'b0;
      end
    end
  end

  // Flags that software clears; the end of the preset pulse clears unit change.
  always_ff @(posedge clk_in) begin
    if (clr_stat) begin
      ms_q <= ms_set;
      err_q <= ms_set[MS_ERROR];
      done_q <= done_ev;
    end else begin
      ms_q <= ms_q | ms_set;
      if (preset_end && !chg_ev) begin
        ms_q[MS_CHANGE] <= 1'b0;
      end
      err_q <= err_q || ms_set[MS_ERROR];
      done_q <= done_q || done_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, skips and the interrupt request.
  logic [11:0] rd_mux;
  always_comb begin
    case (addr_in)
      A_RD_COUNT: rd_mux = wc_q;
      A_RD_ADDR: rd_mux = ca_q;
      A_RD_MAIN: rd_mux = {ms_q[11:1], ms_q[MS_ILLEGAL]};
      A_RD_SECOND: rd_mux = {4'h0, fn_q[FN_CHK], 3'h0, ovr_q, 3'h0};
      A_RD_FUNC: rd_mux = fn_q;
      A_RD_DATA: rd_mux = db_q;
      default: rd_mux = 12'h000;
    endcase
  end
  wire skip_hit = rd_in &&
    ((addr_in == A_SKIP_ERR && err_q) ||
     (addr_in == A_SKIP_IDLE && !busy_q) ||
     (addr_in == A_SKIP_READY && ready) ||
     (addr_in == A_SKIP_DONE && done_q));

  always_ff @(posedge clk_in) begin
    if (clear_everything) begin
      rdata_q <= 12'h000;
      skip_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_in ? rd_mux : 12'h000;
      skip_q <= skip_hit;
      irq_q <= (cmd_q[CM_ERR_IE] && err_q) ||
               (cmd_q[CM_DONE_IE] && done_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transport command lines, decoded from the held registers.
  always_ff @(posedge clk_in) begin
    if (clear_everything) begin
      gap_q <= 1'b0;
      par_q <= 1'b1;
      chk_q <= 1'b0;
      offl_q <= 1'b0;
      rew_q <= 1'b0;
      mark_q <= 1'b0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      spc_q <= 1'b0;
      wd_q <= 8'h00;
    end else begin
      gap_q <= fn_q[FN_GAP];
      par_q <= !cmd_q[CM_PARITY];
      chk_q <= fn_q[FN_CHK];
      offl_q <= fn_q[FN_GO] && code == FC_UNLOAD_TO_LOCAL;
      rew_q <= fn_q[FN_GO] && code == FC_REWIND;
      mark_q <= fn_q[FN_GO] && code == FC_MARK;
      fwd_q <= fn_q[FN_GO] && code == FC_FWD;
      rev_q <= fn_q[FN_GO] && code == FC_REV;
      spc_q <= running && op_space && !space_stop;
      wd_q <= fn_q[FN_DUMP] ? {db_q[7:2], 2'h0} : db_q[7:0];
    end
  end

  assign rdata_out = rdata_q;
  assign skip_out = skip_q;
  assign interrupt_out = irq_q;
  assign transfer_request_out = req_q;
  assign break_addr_out = {field_q, ca_q};
  assign break_data_out = db_q;
  assign unit_select_out = bsel_q;
  assign extended_gap_out = gap_q;
  assign parity_sense_select_out = par_q;
  assign check_char_enable_out = chk_q;
  assign unload_to_local_out = offl_q;
  assign rewind_out = rew_q;
  assign write_mark_out = mark_q;
  assign space_ahead_out = fwd_q;
  assign space_back_out = rev_q;
  assign spacing_out = spc_q;
  assign preset_out = preset_pulse;
  assign start_pulse_out = start_pulse;
  assign write_data_out = wd_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (clear_everything);

  chk_gap_follow: assert property (
    wr_fn ##1 !wr_fn [*2] |-> extended_gap_out == $past(wdata_in[FN_GAP], 2))
    else $error("gap line does not follow function bit");
  chk_parity_odd: assert property (
    wr_cmd ##1 !wr_cmd [*2] |->
      parity_sense_select_out == !$past(wdata_in[CM_PARITY], 2))
    else $error("parity select wrong");
  chk_late_set: assert property (
    late_ev |=> ms_q[MS_LATE] && err_q)
    else $error("late service not flagged");
  chk_irq_done: assert property (
    cmd_q[CM_DONE_IE] && done_q && !wr_cmd |=> interrupt_out)
    else $error("done interrupt missing");
  chk_skip_ready: assert property (
    rd_in && addr_in == A_SKIP_READY && ready |=> skip_out)
    else $error("ready skip missing");
  chk_busy_set: assert property (
    go_new && !wr_db ##1 !done_ev |=> busy_q)
    else $error("busy not set after go");
  chk_preset_start: assert property (
    $fell(preset_pulse) && !$past(clear_everything) |-> ##1 start_pulse)
    else $error("start pulse did not follow preset");
  chk_no_go_idle: assert property (
    state_q == TCC_IDLE && !go_new |=> state_q == TCC_IDLE)
    else $error("operation started without go");
  chk_overrun_bit: assert property (
    ovr_ev |=> ovr_q && err_q)
    else $error("field overrun not recorded");
endmodule // tcc_tape_control

//--- tb/tcc_transport_model.sv
// Behavioural tape transport that answers the command block.
`timescale 1ns/1ps
module tcc_transport_model (
  input wire logic clk_in,
  input wire logic operator_in,
  input wire logic end_req_in,
  input wire logic unload_to_local_in,
  output logic unit_ready_out,
  output logic tape_end_marker_out,
  output logic [7:0] read_data_out
);
  logic local_q = 1'b0;
  logic [7:0] pat_q = 8'h5A;
  // An unloaded unit stays local until the operator brings it back.
  always_ff @(posedge clk_in) begin
    local_q <= operator_in ? 1'b0 : (local_q | unload_to_local_in);
    pat_q <= ~pat_q + 8'h01;
  end
  assign unit_ready_out = ~local_q;
  assign tape_end_marker_out = end_req_in;
  // Outside a character the read lines carry a changing pattern.
  assign read_data_out = pat_q;
endmodule // tcc_transport_model

//--- tb/tape_controller_command_status_tb_top.sv
// Self-checking bench for the tape command block.
`timescale 1ns/1ps
module tape_controller_command_status_tb_top;
  import tcc_pkg::*;
  logic clk_in, reset_n_in, bus_init_in, wr, rd, oper, end_req, sk, unl;
  logic [5:0] addr;
  logic [11:0] wdata, rdata, v, mdat;
  logic [2:0] perr;
  logic ready, tape_end_marker, irq, pre, st, gap, par, chk, rew, sa, sb, spc, fm, gnt;
  logic [7:0] rdat;
  int n_mismatch, num_checks, n;
  tcc_tape_control tcc_tape_control_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .bus_init_in(bus_init_in),
    .power_fail_in(1'b0), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .break_grant_in(gnt), .mem_data_in(mdat),
    .unit_ready_in(ready), .tape_end_marker_in(tape_end_marker),
    .tape_start_marker_in(1'b0), .parity_err_in(perr),
    .file_mark_in(fm), .select_error_in(1'b0), .char_strobe_in(1'b0),
    .record_end_in(1'b0), .read_data_in(rdat), .rdata_out(rdata),
    .skip_out(sk), .interrupt_out(irq), .transfer_request_out(),
    .break_addr_out(), .break_data_out(), .unit_select_out(),
    .extended_gap_out(gap), .parity_sense_select_out(par),
    .check_char_enable_out(chk), .unload_to_local_out(unl),
    .rewind_out(rew), .write_mark_out(), .space_ahead_out(sa),
    .space_back_out(sb), .spacing_out(spc), .preset_out(pre),
    .start_pulse_out(st), .write_data_out());
  tcc_transport_model tcc_transport_model_i (.clk_in(clk_in),
    .operator_in(oper), .end_req_in(end_req), .unload_to_local_in(unl),
    .unit_ready_out(ready), .tape_end_marker_out(tape_end_marker),
    .read_data_out(rdat));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  // Comparison and closing tasks.
  task automatic cmp(input string nm, input logic [11:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One-cycle write strobe beside address and data.
  task automatic wr_op(input logic [5:0] a, input logic [11:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data and skip stand only in the cycle after the strobe.
  task automatic rd_op(input logic [5:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {bus_init_in, wr, rd, oper, end_req, fm, gnt, addr, wdata, mdat,
     perr} = '0;
    n_mismatch = 0;
    num_checks = 0;
    reset_n_in = 1'b0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    settle(4);
    cmp("parity_idle", par, 1'b1);
    rd_op(A_RD_MAIN);
    cmp("status_reset", v, 12'h000);
    wr_op(A_LOAD_CMD, 12'h1C0);
    settle(1);
    cmp("parity_odd", par, 1'b0);
    // Each function code without go: gap and check follow, motion waits.
    for (int c = 0; c < 8; c++) begin
      wr_op(A_LOAD_FUNC, {c[2:0], 9'h180});
      settle(1);
      cmp("gap", gap, 1'b1);
      cmp("chk", chk, 1'b1);
      cmp("unload", unl, 1'b0);
      cmp("rewind", rew, 1'b0);
      cmp("space", {sa, sb}, 2'b00);
      cmp("no_start", pre, 1'b0);
      rd_op(A_RD_SECOND);
      cmp("sec_chk", v[SS_CHK], 1'b1);
    end
    // Code 1 with go rewinds; clear-flags with the unit ready aborts it.
    wr_op(A_LOAD_FUNC, 12'h240);
    settle(1);
    cmp("rewind", rew, 1'b1);
    wr_op(A_CLR_FLAGS, 12'h000);
    // Code 0 with go unloads the unit; go while not ready is illegal.
    wr_op(A_LOAD_FUNC, 12'h040);
    settle(1);
    cmp("unload", unl, 1'b1);
    settle(4);
    rd_op(A_SKIP_READY);
    cmp("skip_not_ready", sk, 1'b0);
    wr_op(A_LOAD_FUNC, 12'h440);
    rd_op(A_RD_MAIN);
    cmp("illegal", {v[MS_ERROR], v[MS_ILLEGAL]}, 2'b11);
    oper <= 1'b1;
    settle(5);
    oper <= 1'b0;
    wr_op(A_CLR_FLAGS, 12'h000);
    wr_op(A_LOAD_CMD, 12'h1C0);
    rd_op(A_SKIP_READY);
    cmp("skip_ready", sk, 1'b1);
    rd_op(A_SKIP_IDLE);
    cmp("skip_idle", sk, 1'b1);
    // End marker: error, interrupt, and the flag outlives the cause.
    end_req <= 1'b1;
    settle(6);
    end_req <= 1'b0;
    settle(6);
    rd_op(A_RD_MAIN);
    cmp("eot", {v[MS_ERROR], v[MS_EOT]}, 2'b11);
    cmp("irq_err", irq, 1'b1);
    rd_op(A_SKIP_ERR);
    cmp("skip_err", sk, 1'b1);
    wr_op(A_CLR_FLAGS, 12'h000);
    rd_op(A_RD_MAIN);
    cmp("clear_everything", v, 12'h000);
    // Parity error driven by the bench, then bus initialize.
    perr <= 3'h4;
    settle(6);
    perr <= 3'h0;
    rd_op(A_RD_MAIN);
    cmp("parity", {v[MS_ERROR], v[MS_PARITY]}, 2'b11);
    bus_init_in <= 1'b1;
    settle(1);
    bus_init_in <= 1'b0;
    rd_op(A_RD_MAIN);
    cmp("init", v, 12'h000);
    // Count and data buffer instructions; data load sets done.
    wr_op(A_LOAD_CMD, 12'h040);
    wr_op(A_LOAD_COUNT, 12'hFF0);
    wr_op(A_LOAD_DATA, 12'hABC);
    rd_op(A_RD_COUNT);
    cmp("count", v, 12'hFF0);
    rd_op(A_RD_DATA);
    cmp("data", v, 12'hABC);
    rd_op(A_SKIP_DONE);
    cmp("skip_done", sk, 1'b1);
    cmp("irq_done", irq, 1'b1);
    wr_op(A_CLR_FLAGS, 12'h000);
    // Manual break request granted at the top of the last field.
    wr_op(A_LOAD_CMD, 12'h038);
    wr_op(A_LOAD_FUNC, 12'h820);
    wr_op(A_LOAD_ADDR, 12'hFFF);
    wr_op(A_SET_REQ, 12'h000);
    gnt <= 1'b1;
    mdat <= 12'h5A3;
    settle(1);
    gnt <= 1'b0;
    rd_op(A_RD_ADDR);
    cmp("addr_wrap", v, 12'h000);
    rd_op(A_RD_SECOND);
    cmp("overrun", v[SS_OVERRUN], 1'b1);
    rd_op(A_RD_DATA);
    cmp("grant_data", v, 12'h5A3);
    rd_op(A_RD_MAIN);
    cmp("overrun_err", v[MS_ERROR], 1'b1);
    wr_op(A_CLR_FLAGS, 12'h000);
    // Go with the unit ready: preset and start widths, then spacing.
    wr_op(A_LOAD_FUNC, 12'hC40);
    settle(0);
    n = 0;
    while (pre !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    n = 0;
    while (pre === 1'b1 && n < 2000) begin
      settle(1);
      n++;
    end
    cmp("preset_len", n, 625);
    settle(1);
    cmp("start_on", st, 1'b1);
    n = 0;
    while (st === 1'b1 && n < 3000) begin
      settle(1);
      n++;
    end
    cmp("start_len", n, 1250);
    settle(2);
    rd_op(A_SKIP_IDLE);
    cmp("busy", sk, 1'b0);
    cmp("spacing", {sa, spc}, 2'b11);
    // A file mark ends the spacing run and raises the error flag.
    fm <= 1'b1;
    settle(4);
    fm <= 1'b0;
    settle(2);
    cmp("space_end", spc, 1'b0);
    rd_op(A_SKIP_IDLE);
    cmp("not_busy", sk, 1'b1);
    rd_op(A_RD_MAIN);
    cmp("mark", {v[MS_ERROR], v[MS_MARK]}, 2'b11);
    tally_and_finish();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tape_controller_command_status_tb_top
